// File: rtl/dpllc_pkg.sv
// package: constants, register map and types of the dual pll divider configuration block
package dpllc_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_MAIN_DIV  = 8'h04;
    localparam logic [7:0] ADDR_AUX_DIV   = 8'h08;
    localparam logic [7:0] ADDR_XTAL_KHZ  = 8'h0c;
    localparam logic [7:0] ADDR_STATUS    = 8'h10;
    localparam logic [7:0] ADDR_MAIN_VCO  = 8'h14;
    localparam logic [7:0] ADDR_MAIN_OUT  = 8'h18;
    localparam logic [7:0] ADDR_AUX_VCO   = 8'h1c;
    localparam logic [7:0] ADDR_AUX_OUT   = 8'h20;
    // ctrl fields
    localparam int CTRL_SRC_LSB  = 0;  // new_source_select [2:0]
    localparam int CTRL_SWREQ    = 3;  // switch_request_bit
    localparam int CTRL_AUX_EN   = 4;  // auxiliary_loop enable
    localparam int CTRL_AUX_SRC  = 5;  // 0 internal rc, 1 crystal
    // divider register fields
    localparam int DIV_PRE_LSB = 0;
    localparam int DIV_FB_LSB  = 8;
    localparam int DIV_P1_LSB  = 16;
    localparam int DIV_P2_LSB  = 20;
    // status fields
    localparam int ST_COSC_LSB  = 0;
    localparam int ST_MAIN_OK   = 4;
    localparam int ST_AUX_OK    = 5;
    localparam int ST_AUX_RUN   = 6;
    localparam int ST_ERR_MIX   = 8;   // pll to pll switch refused
    localparam int ST_ERR_RANGE = 9;   // switch to out-of-range pll refused
    localparam int ST_ERR_LOCK  = 10;  // divider write while on pll ignored
    // reset values
    localparam logic [3:0]  RST_PRE  = 4'h1;
    localparam logic [7:0]  RST_FB   = 8'h32;
    localparam logic [2:0]  RST_POST = 3'h1;
    localparam logic [23:0] RST_XTAL = 24'h002710;  // 10000 khz
    // frequency limits, khz
    localparam logic [31:0] RC_KHZ      = 32'd8000;
    localparam logic [31:0] IN_MIN_KHZ  = 32'd8000;
    localparam logic [31:0] IN_MAX_KHZ  = 32'd64000;
    localparam logic [31:0] PFD_MIN_KHZ = 32'd8000;
    localparam int          PFD_VCO_DIV = 16;
    localparam logic [31:0] VCO_MIN_KHZ = 32'd400000;
    localparam logic [31:0] VCO_MAX_KHZ = 32'd1600000;
    // clock switch settle time
    localparam int CLK_MHZ       = 50;
    localparam int SWITCH_NS     = 2000;
    localparam int SWITCH_CYCLES = (SWITCH_NS * CLK_MHZ + 999) / 1000;
    // system clock source codes
    typedef enum logic [2:0] {
        SRC_RC       = 3'h0,
        SRC_RC_PLL   = 3'h1,
        SRC_XTAL     = 3'h2,
        SRC_XTAL_PLL = 3'h3
    } dpllc_src_t;
    typedef enum {ST_IDLE, ST_SWITCH} dpllc_state_t;
endpackage

// File: rtl/dpllc_loop_if.sv
// interface: one pll configuration and its computed frequencies
`timescale 1ns/100ps
interface dpllc_loop_if;
    logic [31:0] in_khz;
    logic [3:0]  pre;
    logic [7:0]  fb;
    logic [2:0]  post1;
    logic [2:0]  post2;
    logic [31:0] vco_khz;
    logic [31:0] out_khz;
    logic        in_range;
    modport ctl  (output in_khz, pre, fb, post1, post2, input vco_khz, out_khz, in_range);
    modport calc (input in_khz, pre, fb, post1, post2, output vco_khz, out_khz, in_range);
endinterface

// File: rtl/dpllc_loop_calc.sv
// module: frequency calculation and range check of one pll
`timescale 1ns/100ps
module dpllc_loop_calc (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration and results
    dpllc_loop_if.calc lp
);
    logic [39:0] prod;
    logic [9:0]  post_div;
    logic [31:0] vco_d;
    logic [31:0] out_d;
    logic [31:0] pfd_d;
    logic        ok_d;

    // vco and output frequency, a zero divisor gives zero
    always_comb begin
        prod     = {8'h00, lp.in_khz} * {32'h0, lp.fb};
        post_div = {6'h0, lp.pre} * {7'h0, lp.post1} * {7'h0, lp.post2};
        vco_d    = 32'((lp.pre == 4'h0) ? 40'h0 : prod / {36'h0, lp.pre});        // RULE4 RULE13
        out_d    = 32'((post_div == 10'h0) ? 40'h0 : prod / {30'h0, post_div});   // RULE5 RULE14
        pfd_d    = (lp.pre == 4'h0) ? 32'h0 : lp.in_khz / {28'h0, lp.pre};
        // every documented limit is checked so software sees a bad setting
        ok_d = (lp.in_khz >= dpllc_pkg::IN_MIN_KHZ) && (lp.in_khz <= dpllc_pkg::IN_MAX_KHZ)  // RULE1 RULE10
            && (pfd_d >= dpllc_pkg::PFD_MIN_KHZ)                                            // RULE2 RULE11
            && (36'(pfd_d) * 36'(dpllc_pkg::PFD_VCO_DIV) <= 36'(vco_d))                      // RULE2 RULE11
            && (vco_d >= dpllc_pkg::VCO_MIN_KHZ) && (vco_d <= dpllc_pkg::VCO_MAX_KHZ)        // RULE3 RULE12
            && (post_div != 10'h0);
    end

    // results registered to break the divider path
    always_ff @(posedge mclk) begin
        if (rst) begin
            lp.vco_khz  <= 32'h0;
            lp.out_khz  <= 32'h0;
            lp.in_range <= 1'b0;
        end else begin
            lp.vco_khz  <= vco_d;
            lp.out_khz  <= out_d;
            lp.in_range <= ok_d;
        end
    end
endmodule // dpllc_loop_calc

// File: rtl/dpllc_top.sv
// module: dual pll divider configuration with wishbone register slave
// Functional notes
// RULE1: main loop input kept within 8..64 MHz
// RULE2: main phase detector 8 MHz to vco/16
// RULE3: main vco kept within 400..1600 MHz
// RULE4: main vco is input times fb over pre
// RULE5: main output divides vco by both postdividers
// RULE6: no main divider change while on pll
// RULE7: no direct pll to pll switch
// RULE8: rc or crystal may feed main loop
// RULE9: auxiliary loop runs independent of system clock
// RULE10: aux input kept within 8..64 MHz
// RULE11: aux phase detector 8 MHz to vco/16
// RULE12: aux vco kept within 400..1600 MHz
// RULE13: aux vco is input times fb over pre
// RULE14: aux output divides vco by both postdividers
// RULE15: write source code then set request bit
// RULE16: request bit clears when switch completes
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module dpllc_top (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // clock tree state
    output logic      [2:0]  sys_source,
    output logic             main_loop_enable,
    output logic      [31:0] main_loop_output_freq,
    output logic             aux_loop_enable,
    output logic      [31:0] aux_loop_output_freq
);
    dpllc_loop_if main_lp ();
    dpllc_loop_if aux_lp ();

    logic [2:0]  new_source_select_q;
    logic        switch_request_bit_q;
    logic        aux_en_q;
    logic        aux_src_q;
    logic [31:0] main_div_q;
    logic [31:0] aux_div_q;
    logic [23:0] xtal_khz_q;
    logic [2:0]  cur_src_q;
    logic [2:0]  err_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic [15:0] settle_q;
    logic        req_seen_q;
    dpllc_pkg::dpllc_state_t state_q;
    logic        bus_req;
    logic        wr_ctrl;
    logic        wr_main;
    logic        wr_aux;
    logic        wr_xtal;
    logic        wr_stat;
    logic        start_sw;
    logic        refuse_mix;
    logic        refuse_range;
    logic        done_sw;
    logic        main_locked;

    // true for the two sources that run through the main loop
    function automatic logic is_pll_src(input logic [2:0] s);
        is_pll_src = (s == dpllc_pkg::SRC_RC_PLL) || (s == dpllc_pkg::SRC_XTAL_PLL);
    endfunction

    // merge write data under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    // bus decode; one access per request, answered one edge later
    assign bus_req = cyc_i && stb_i && !ack_q;
    assign wr_ctrl = bus_req && we_i && (adr_i == dpllc_pkg::ADDR_CTRL);
    assign wr_main = bus_req && we_i && (adr_i == dpllc_pkg::ADDR_MAIN_DIV);
    assign wr_aux  = bus_req && we_i && (adr_i == dpllc_pkg::ADDR_AUX_DIV);
    assign wr_xtal = bus_req && we_i && (adr_i == dpllc_pkg::ADDR_XTAL_KHZ);
    assign wr_stat = bus_req && we_i && (adr_i == dpllc_pkg::ADDR_STATUS);
    // main dividers frozen while the system runs from the main loop
    assign main_locked = is_pll_src(cur_src_q);

    // switch start decision: pll to another pll and bad settings are refused
    // judged one cycle late so the range flag already reflects the new source code
    assign start_sw     = (state_q == dpllc_pkg::ST_IDLE) && switch_request_bit_q && req_seen_q;
    assign refuse_mix   = start_sw && is_pll_src(new_source_select_q) && is_pll_src(cur_src_q)
                          && (new_source_select_q != cur_src_q);                                 // RULE7
    assign refuse_range = start_sw && is_pll_src(new_source_select_q) && !main_lp.in_range;     // RULE1 RULE2 RULE3
    assign done_sw      = (state_q == dpllc_pkg::ST_SWITCH) && (settle_q == 16'h0);

    // main loop input follows the running source while locked, else the requested one
    assign main_lp.in_khz = ((main_locked ? cur_src_q : new_source_select_q) == dpllc_pkg::SRC_XTAL_PLL)
                            ? {8'h0, xtal_khz_q} : dpllc_pkg::RC_KHZ;                            // RULE8
    assign main_lp.pre    = main_div_q[dpllc_pkg::DIV_PRE_LSB +: 4];
    assign main_lp.fb     = main_div_q[dpllc_pkg::DIV_FB_LSB +: 8];
    assign main_lp.post1  = main_div_q[dpllc_pkg::DIV_P1_LSB +: 3];
    assign main_lp.post2  = main_div_q[dpllc_pkg::DIV_P2_LSB +: 3];
    // aux loop has its own input choice, never tied to the system source
    assign aux_lp.in_khz  = aux_src_q ? {8'h0, xtal_khz_q} : dpllc_pkg::RC_KHZ;                 // RULE9
    assign aux_lp.pre     = aux_div_q[dpllc_pkg::DIV_PRE_LSB +: 4];
    assign aux_lp.fb      = aux_div_q[dpllc_pkg::DIV_FB_LSB +: 8];
    assign aux_lp.post1   = aux_div_q[dpllc_pkg::DIV_P1_LSB +: 3];
    assign aux_lp.post2   = aux_div_q[dpllc_pkg::DIV_P2_LSB +: 3];

    dpllc_loop_calc u_main_calc (
        .mclk (mclk),
        .rst  (rst),
        .lp   (main_lp)
    );

    dpllc_loop_calc u_aux_calc (
        .mclk (mclk),
        .rst  (rst),
        .lp   (aux_lp)
    );

    // control register; hardware clear of the request wins over a software write
    always_ff @(posedge mclk) begin
        if (rst) begin
            new_source_select_q  <= dpllc_pkg::SRC_RC;
            switch_request_bit_q <= 1'b0;
            aux_en_q             <= 1'b0;
            aux_src_q            <= 1'b0;
        end else begin
            if (wr_ctrl && sel_i[0]) begin
                new_source_select_q <= dat_i[dpllc_pkg::CTRL_SRC_LSB +: 3];                       // RULE15
                aux_en_q            <= dat_i[dpllc_pkg::CTRL_AUX_EN];
                aux_src_q           <= dat_i[dpllc_pkg::CTRL_AUX_SRC];
                if (dat_i[dpllc_pkg::CTRL_SWREQ]) begin
                    switch_request_bit_q <= 1'b1;                                                // RULE15
                end
            end
            if (done_sw || refuse_mix || refuse_range) begin
                switch_request_bit_q <= 1'b0;                                                    // RULE16
            end
        end
    end

    // divider and crystal registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            main_div_q <= {9'h0, dpllc_pkg::RST_POST, 1'b0, dpllc_pkg::RST_POST, dpllc_pkg::RST_FB, 4'h0, dpllc_pkg::RST_PRE};
            aux_div_q  <= {9'h0, dpllc_pkg::RST_POST, 1'b0, dpllc_pkg::RST_POST, dpllc_pkg::RST_FB, 4'h0, dpllc_pkg::RST_PRE};
            xtal_khz_q <= dpllc_pkg::RST_XTAL;
        end else begin
            // a write while the main loop clocks the system would glitch it: ignored
            if (wr_main && !main_locked) begin
                main_div_q <= merge(main_div_q, dat_i, sel_i) & 32'h0077ff0f;                    // RULE6
            end
            if (wr_aux) begin
                aux_div_q <= merge(aux_div_q, dat_i, sel_i) & 32'h0077ff0f;
            end
            // crystal frequency frozen only while the main loop runs from the crystal
            if (wr_xtal && !(main_locked && cur_src_q == dpllc_pkg::SRC_XTAL_PLL)) begin
                xtal_khz_q <= 24'(merge({8'h0, xtal_khz_q}, dat_i, sel_i));
            end
        end
    end

    // request delay; the range flag is registered, so it lags a new source code by one edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            req_seen_q <= 1'b0;
        end else begin
            req_seen_q <= switch_request_bit_q;                                                  // RULE1 RULE2 RULE3
        end
    end

    // switch sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q   <= dpllc_pkg::ST_IDLE;
            settle_q  <= 16'h0;
            cur_src_q <= dpllc_pkg::SRC_RC;
        end else begin
            case (state_q)
                dpllc_pkg::ST_IDLE: begin
                    if (start_sw && !refuse_mix && !refuse_range) begin
                        state_q  <= dpllc_pkg::ST_SWITCH;                                         // RULE15
                        settle_q <= 16'(dpllc_pkg::SWITCH_CYCLES - 1);
                    end
                end
                dpllc_pkg::ST_SWITCH: begin
                    if (settle_q == 16'h0) begin
                        cur_src_q <= new_source_select_q;
                        state_q   <= dpllc_pkg::ST_IDLE;
                    end else begin
                        settle_q <= settle_q - 16'h1;
                    end
                end
                default: begin
                    state_q <= dpllc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // sticky error flags, write one to clear, a new event wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            err_q <= 3'h0;
        end else begin
            err_q <= (err_q & ~((wr_stat && sel_i[1]) ? dat_i[dpllc_pkg::ST_ERR_MIX +: 3] : 3'h0))
                   | {wr_main && main_locked, refuse_range, refuse_mix};                         // RULE6 RULE7
        end
    end

    // read mux and ack; unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= bus_req;
            if (bus_req) begin
                case (adr_i)
                    dpllc_pkg::ADDR_CTRL:     dat_q <= {26'h0, aux_src_q, aux_en_q, switch_request_bit_q,
                                                        new_source_select_q};
                    dpllc_pkg::ADDR_MAIN_DIV: dat_q <= main_div_q;
                    dpllc_pkg::ADDR_AUX_DIV:  dat_q <= aux_div_q;
                    dpllc_pkg::ADDR_XTAL_KHZ: dat_q <= {8'h0, xtal_khz_q};
                    dpllc_pkg::ADDR_STATUS:   dat_q <= {21'h0, err_q, 1'b0, aux_en_q, aux_lp.in_range,
                                                        main_lp.in_range, 1'b0, cur_src_q};
                    dpllc_pkg::ADDR_MAIN_VCO: dat_q <= main_lp.vco_khz;
                    dpllc_pkg::ADDR_MAIN_OUT: dat_q <= main_lp.out_khz;
                    dpllc_pkg::ADDR_AUX_VCO:  dat_q <= aux_lp.vco_khz;
                    dpllc_pkg::ADDR_AUX_OUT:  dat_q <= aux_lp.out_khz;
                    default:                  dat_q <= 32'h0;
                endcase
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // clock tree outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            sys_source            <= dpllc_pkg::SRC_RC;
            main_loop_enable      <= 1'b0;
            main_loop_output_freq <= 32'h0;
            aux_loop_enable       <= 1'b0;
            aux_loop_output_freq  <= 32'h0;
        end else begin
            sys_source            <= cur_src_q;
            main_loop_enable      <= main_locked || (state_q == dpllc_pkg::ST_SWITCH && is_pll_src(new_source_select_q));
            main_loop_output_freq <= main_locked ? main_lp.out_khz : 32'h0;                     // RULE5
            // aux refuses to run on an illegal setting
            aux_loop_enable       <= aux_en_q && aux_lp.in_range;                                // RULE9 RULE10 RULE11 RULE12
            aux_loop_output_freq  <= (aux_en_q && aux_lp.in_range) ? aux_lp.out_khz : 32'h0;     // RULE14
        end
    end
endmodule // dpllc_top

// File: testbench/dpllc_properties.sv
// checker: bus handshake and clock-switch properties of the pll configuration block
`timescale 1ns/100ps
module dpllc_properties (
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    // wishbone slave
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // clock tree state
    input wire logic [2:0]  sys_source,
    input wire logic        main_loop_enable,
    input wire logic [31:0] main_loop_output_freq,
    input wire logic        aux_loop_enable,
    input wire logic [31:0] aux_loop_output_freq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic req;
    logic ctrl_sw;
    logic on_pll;
    // a request is taken only while ack is low
    assign req     = cyc_i && stb_i && !ack_o;
    assign ctrl_sw = req && we_i && adr_i == dpllc_pkg::ADDR_CTRL && sel_i[0] && dat_i[dpllc_pkg::CTRL_SWREQ];
    assign on_pll  = sys_source == 3'h1 || sys_source == 3'h3;

    chk_ack_next_cycle: assert property (req |=> ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_no_stray_ack: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    chk_unmapped_reads_zero: assert property (req && !we_i && adr_i > 8'h23 |=> ack_o && dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_no_pll_hop: assert property ($changed(sys_source) && on_pll |-> !($past(sys_source) inside {3'h1, 3'h3}))
        else $error("direct pll to pll switch");
    chk_switch_settles: assert property (ctrl_sw |=> $stable(sys_source) [*8])
        else $error("source changed without settle time");
    chk_off_pll_quiet: assert property (!on_pll && $stable(sys_source) |-> main_loop_output_freq == 32'h0)
        else $error("main output while off pll");
    chk_pll_enabled: assert property (on_pll && $stable(sys_source) |-> main_loop_enable)
        else $error("main loop off while system on pll");
    chk_aux_out_gated: assert property (!aux_loop_enable && $past(!aux_loop_enable) |-> aux_loop_output_freq == 32'h0)
        else $error("aux output while aux disabled");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !ack_o && sys_source == 3'h0)
        else $error("outputs not cleared by reset");
endmodule // dpllc_properties

bind dpllc_top dpllc_properties dpllc_properties_i (.mclk, .rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .sys_source, .main_loop_enable, .main_loop_output_freq, .aux_loop_enable, .aux_loop_output_freq);

// File: testbench/testbench.sv
// testbench: register, frequency and clock-switch checks of the pll configuration block
`timescale 1ns/100ps
module testbench;
    logic        mclk, rst, cyc, stb, we, ack_o, main_en, aux_en;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [2:0]  src;
    logic [31:0] wdat, dat_o, main_freq, aux_freq, rd, fin, ok;
    int          errors, num_checks;
    // divider words: pre [3:0], fb [15:8], post1 [18:16], post2 [22:20]
    logic [31:0] rows [6] = '{32'h00157d01, 32'h0024c801, 32'h0011c901, 32'h00173101, 32'h00116402, 32'h00113200};

    dpllc_top dpllc_top_i (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .sys_source(src), .main_loop_enable(main_en),
        .main_loop_output_freq(main_freq), .aux_loop_enable(aux_en), .aux_loop_output_freq(aux_freq));

    // free-running 50 mhz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task finish_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle: request held until ack is sampled high at a rising edge, data taken and released there
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            finish_test();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd & mask, exp);
    endtask

    // request a switch with aux kept enabled on crystal, poll until the request bit drops
    task sw(input logic [2:0] code);
        int n;
        n = 0;
        wb(1'b1, dpllc_pkg::ADDR_CTRL, {26'h0, 2'h3, 1'b1, code});
        do begin
            wb(1'b0, dpllc_pkg::ADDR_CTRL, 32'h0);
            n++;
        end while (rd[3] !== 1'b0 && n < 100);
        chk({31'h0, rd[3]}, 32'h0);
        @(negedge mclk);
    endtask

    // kind 0 vco, 1 output, 2 in-range flag; zero divisor gives zero
    function automatic logic [31:0] fcalc(input logic [31:0] f, input logic [31:0] w, input int kind);
        logic [31:0] pre, den, vco, pfd;
        pre = {28'h0, w[3:0]};
        den = pre * {29'h0, w[18:16]} * {29'h0, w[22:20]};
        vco = (pre != 0) ? f * {24'h0, w[15:8]} / pre : 32'h0;
        pfd = (pre != 0) ? f / pre : 32'h0;
        if (kind == 0) return vco;
        if (kind == 1) return (den != 0) ? f * {24'h0, w[15:8]} / den : 32'h0;
        return {31'h0, den != 0 && f >= dpllc_pkg::IN_MIN_KHZ && f <= dpllc_pkg::IN_MAX_KHZ && pfd >= dpllc_pkg::PFD_MIN_KHZ
            && pfd <= vco / dpllc_pkg::PFD_VCO_DIV && vco >= dpllc_pkg::VCO_MIN_KHZ && vco <= dpllc_pkg::VCO_MAX_KHZ};
    endfunction

    // watchdog sized well above the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        finish_test();
    end

    initial begin
        {rst, cyc, stb, we, adr, wdat, errors, num_checks} = '0;
        rst = 1'b1;
        sel = 4'hf;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({28'h0, ack_o, src}, 32'h0);
        rdc(dpllc_pkg::ADDR_XTAL_KHZ, 32'hffffffff, 32'h00002710);
        rdc(dpllc_pkg::ADDR_MAIN_VCO, 32'hffffffff, 32'd400000);
        rdc(8'h40, 32'hffffffff, 32'h0);
        // main loop on rc, then aux loop on a 16 mhz crystal
        for (int l = 0; l < 2; l++) begin
            fin = l ? 32'd16000 : dpllc_pkg::RC_KHZ;
            for (int i = 0; i < 6; i++) begin
                wb(1'b1, l ? dpllc_pkg::ADDR_AUX_DIV : dpllc_pkg::ADDR_MAIN_DIV, rows[i]);
                rdc(l ? dpllc_pkg::ADDR_AUX_VCO : dpllc_pkg::ADDR_MAIN_VCO, '1, fcalc(fin, rows[i], 0));
                rdc(l ? dpllc_pkg::ADDR_AUX_OUT : dpllc_pkg::ADDR_MAIN_OUT, '1, fcalc(fin, rows[i], 1));
                ok = fcalc(fin, rows[i], 2);
                rdc(dpllc_pkg::ADDR_STATUS, 32'h1 << (l ? 5 : 4), ok << (l ? 5 : 4));
                @(negedge mclk);
                if (l) chk({31'h0, aux_en}, ok);
                if (l) chk(aux_freq, ok[0] ? fcalc(fin, rows[i], 1) : 32'h0);
            end
            wb(1'b1, dpllc_pkg::ADDR_XTAL_KHZ, 32'd16000);
            wb(1'b1, dpllc_pkg::ADDR_CTRL, 32'h30);
        end
        wb(1'b1, dpllc_pkg::ADDR_MAIN_DIV, rows[0]);
        sw(3'h1);
        chk({29'h0, src}, 32'h1);
        chk({main_en, main_freq[30:0]}, {1'b1, 31'd200000});
        wb(1'b1, dpllc_pkg::ADDR_MAIN_DIV, rows[1]);
        rdc(dpllc_pkg::ADDR_MAIN_VCO, '1, 32'd1000000);
        rdc(dpllc_pkg::ADDR_STATUS, 32'h400, 32'h400);
        sw(3'h3);
        chk({29'h0, src}, 32'h1);
        rdc(dpllc_pkg::ADDR_STATUS, 32'h107, 32'h101);
        chk(main_freq, 32'd200000);
        // sticky errors cleared by writing ones, so later flags are fresh
        wb(1'b1, dpllc_pkg::ADDR_STATUS, 32'h700);
        rdc(dpllc_pkg::ADDR_STATUS, 32'h700, 32'h0);
        sw(3'h0);
        chk({src, main_freq[28:0]}, 32'h0);
        wb(1'b1, dpllc_pkg::ADDR_MAIN_DIV, rows[0]);
        sw(3'h3);
        chk({29'h0, src}, 32'h0);
        rdc(dpllc_pkg::ADDR_STATUS, 32'h200, 32'h200);
        wb(1'b1, dpllc_pkg::ADDR_MAIN_DIV, 32'h00146402);
        sw(3'h3);
        chk({29'h0, src}, 32'h3);
        chk(main_freq, 32'd200000);
        // reset in mid-run drops the system back to the rc source and reset dividers
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk({ack_o, main_en, aux_en, src, main_freq[25:0]}, 32'h0);
        rdc(dpllc_pkg::ADDR_MAIN_DIV, '1, 32'h00113201);
        finish_test();
    end
endmodule // testbench
